// *** src/twg_map.svh ***
`ifndef TWG_MAP_SVH
`define TWG_MAP_SVH
`define TWG_ZERO16 16'h0000
`define TWG_ONE16 16'h0001
`define TWG_ZERO8 8'h00
`define TWG_ONE8 8'h01
`define TWG_PSC_ZERO 10'h000
`define TWG_PSC_ONE 10'h001
`define TWG_CMD_NONE 2'h0
`define TWG_CMD_UPDATE 2'h1
`define TWG_CMD_RESTART 2'h2
`define TWG_CMD_RESET 2'h3
`define TWG_LO 7:0
`define TWG_HI 15:8
`define TWG_BYTE_W 8
`define TWG_PER_INIT 16'hffff
`define TWG_BV_PER 3
`define TWG_MASK_DIV1 10'h000
`define TWG_MASK_DIV2 10'h001
`define TWG_MASK_DIV4 10'h003
`define TWG_MASK_DIV8 10'h007
`define TWG_MASK_DIV16 10'h00f
`define TWG_MASK_DIV64 10'h03f
`define TWG_MASK_DIV256 10'h0ff
`define TWG_MASK_DIV1024 10'h3ff
`endif

// *** src/twg_pkg.sv ***
package twg_pkg;
  typedef enum logic [2:0] {
    TWG_NORMAL = 3'h0,
    TWG_FRQ = 3'h1,
    TWG_SINGLE = 3'h3,
    TWG_DUAL = 3'h5
  } twg_mode_e;
  typedef enum logic [2:0] {
    TWG_DIV1 = 3'h0,
    TWG_DIV2 = 3'h1,
    TWG_DIV4 = 3'h2,
    TWG_DIV8 = 3'h3,
    TWG_DIV16 = 3'h4,
    TWG_DIV64 = 3'h5,
    TWG_DIV256 = 3'h6,
    TWG_DIV1024 = 3'h7
  } twg_psc_e;
endpackage

// *** src/twg_sixteen_bit_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "twg_map.svh"
module twg_sixteen_bit_timer (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // control
  input wire logic ENABLE,
  input wire logic [2:0] PRESCALE_SELECT,
  input wire logic [2:0] WAVEFORM_KIND,
  input wire logic [2:0] CHANNEL_OUTPUT_ON,
  input wire logic COUNT_DOWN,
  input wire logic UPDATE_LOCK,
  input wire logic DUAL_BYTE_SPLIT,
  input wire logic [1:0] COMMAND,
  // values written by software
  input wire logic [15:0] PERIOD_BUFFER,
  input wire logic PERIOD_BUFFER_WRITE,
  input wire logic [47:0] CHANNEL_MATCH_BUFFER,
  input wire logic [2:0] CHANNEL_MATCH_WRITE,
  // port side
  input wire logic [5:0] PIN_OUTPUT_LATCH,
  input wire logic [5:0] PIN_INVERT,
  // outputs
  output logic [5:0] PIN_VALUE,
  output logic [5:0] WAVE_OUTPUT_N,
  output logic [15:0] COUNT_VALUE,
  output logic [15:0] PERIOD_VALUE,
  output logic [47:0] CHANNEL_MATCH_VALUE,
  output logic [3:0] BUFFER_VALID,
  output logic [2:0] MATCH_PULSE
);
  logic [15:0] cnt_r;
  logic [15:0] per_r;
  logic [15:0] cmp_r [0:2];
  logic [15:0] per_buf_r;
  logic [15:0] cmp_buf_r [0:2];
  logic [3:0] bv_r;
  logic [5:0] wo_r;
  logic [9:0] psc_r;
  logic dir_r;
  logic [2:0] match_r;
  logic [7:0] byte_nxt [0:1];

  logic tick;
  logic clear_all;
  logic restart;
  logic soft_reset;
  logic at_bottom;
  logic at_top;
  logic update_cond;
  logic do_update;
  logic [15:0] limit;
  logic wg_on;

  twg_pkg::twg_mode_e mode;

  assign mode = twg_pkg::twg_mode_e'(WAVEFORM_KIND);
  assign wg_on = (mode == twg_pkg::TWG_FRQ) || (mode == twg_pkg::TWG_SINGLE) || (mode == twg_pkg::TWG_DUAL);
  assign restart = (COMMAND == `TWG_CMD_RESTART);
  // reset is only honoured while stopped; a running timer ignores it
  assign soft_reset = (COMMAND == `TWG_CMD_RESET) && !ENABLE;
  // both commands clear the counter, the prescaler and the waveforms
  assign clear_all = restart || soft_reset;

  function automatic logic [9:0] div_mask(input logic [2:0] sel);
    case (twg_pkg::twg_psc_e'(sel))
      twg_pkg::TWG_DIV1: div_mask = `TWG_MASK_DIV1;
      twg_pkg::TWG_DIV2: div_mask = `TWG_MASK_DIV2;
      twg_pkg::TWG_DIV4: div_mask = `TWG_MASK_DIV4;
      twg_pkg::TWG_DIV8: div_mask = `TWG_MASK_DIV8;
      twg_pkg::TWG_DIV16: div_mask = `TWG_MASK_DIV16;
      twg_pkg::TWG_DIV64: div_mask = `TWG_MASK_DIV64;
      twg_pkg::TWG_DIV256: div_mask = `TWG_MASK_DIV256;
      default: div_mask = `TWG_MASK_DIV1024;
    endcase
  endfunction

  // compare hits, shared by the match pulse and every waveform mode
  function automatic logic hits(input logic [15:0] a, input logic [15:0] b);
    hits = (a == b);
  endfunction

  function automatic logic byte_hits(input logic [7:0] a, input logic [7:0] b);
    byte_hits = (a == b);
  endfunction

  // split halves: low at bottom, set on match; out-of-range values never set, so they stay low
  function automatic logic split_level(input logic cur, input logic [7:0] cnt, input logic [7:0] cmp);
    if (cnt == `TWG_ZERO8) begin
      split_level = 1'b0;
    end else if (byte_hits(cnt, cmp)) begin
      split_level = 1'b1;
    end else begin
      split_level = cur;
    end
  endfunction

  // a tick fires while ENABLE is high whenever the masked prescaler bits are all zero
  assign tick = ENABLE && ((psc_r & div_mask(PRESCALE_SELECT)) == `TWG_PSC_ZERO);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      psc_r <= `TWG_PSC_ZERO;
    end else if (!ENABLE || clear_all) begin
      psc_r <= `TWG_PSC_ZERO;
    end else begin
      psc_r <= psc_r + `TWG_PSC_ONE;
    end
  end

  assign limit = (mode == twg_pkg::TWG_FRQ) ? cmp_r[0] : per_r;
  assign at_bottom = (cnt_r == `TWG_ZERO16);
  assign at_top = (cnt_r == limit);
  // update lands at the end of a period, never in split mode: top in dual slope turnaround is skipped for symmetry
  always_comb begin
    update_cond = 1'b0;
    if (DUAL_BYTE_SPLIT) begin
      update_cond = 1'b0;
    end else if (mode == twg_pkg::TWG_DUAL) begin
      update_cond = at_bottom && dir_r;
    end else if (dir_r) begin
      update_cond = at_bottom;
    end else begin
      update_cond = at_top;
    end
  end
  assign do_update = (COMMAND == `TWG_CMD_UPDATE) || (tick && update_cond && !UPDATE_LOCK);

  // split mode: each byte counts down on its own and reloads its own period byte
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_byte
      always_comb begin
        if (cnt_r[`TWG_BYTE_W*b +: `TWG_BYTE_W] == `TWG_ZERO8) begin
          byte_nxt[b] = per_r[`TWG_BYTE_W*b +: `TWG_BYTE_W];
        end else begin
          byte_nxt[b] = cnt_r[`TWG_BYTE_W*b +: `TWG_BYTE_W] - `TWG_ONE8;
        end
      end
    end
  endgenerate

  // counter and direction
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= `TWG_ZERO16;
      dir_r <= 1'b0;
    end else if (clear_all) begin
      cnt_r <= `TWG_ZERO16;
      dir_r <= COUNT_DOWN;
    end else if (tick) begin
      if (DUAL_BYTE_SPLIT) begin
        cnt_r[`TWG_LO] <= byte_nxt[0];
        cnt_r[`TWG_HI] <= byte_nxt[1];
      end else if (mode == twg_pkg::TWG_DUAL) begin
        if (!dir_r) begin
          cnt_r <= at_top ? cnt_r - `TWG_ONE16 : cnt_r + `TWG_ONE16;
          dir_r <= at_top;
        end else begin
          cnt_r <= at_bottom ? cnt_r + `TWG_ONE16 : cnt_r - `TWG_ONE16;
          dir_r <= !at_bottom;
        end
      end else if (COUNT_DOWN) begin
        cnt_r <= at_bottom ? limit : cnt_r - `TWG_ONE16;
        dir_r <= 1'b1;
      end else begin
        cnt_r <= (cnt_r >= limit) ? `TWG_ZERO16 : cnt_r + `TWG_ONE16;
        dir_r <= 1'b0;
      end
    end else if (mode != twg_pkg::TWG_DUAL) begin
      dir_r <= COUNT_DOWN;
    end
  end

  // period buffer, written by software at any time
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      per_buf_r <= `TWG_PER_INIT;
    end else if (soft_reset) begin
      per_buf_r <= `TWG_PER_INIT;
    end else if (PERIOD_BUFFER_WRITE) begin
      per_buf_r <= PERIOD_BUFFER;
    end
  end

  // active period, taken from the buffer only when it is marked valid
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      per_r <= `TWG_PER_INIT;
    end else if (soft_reset) begin
      per_r <= `TWG_PER_INIT;
    end else if (do_update && bv_r[`TWG_BV_PER]) begin
      per_r <= per_buf_r;
    end
  end

  // valid flags: a new write in the update cycle keeps its flag, so the set wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bv_r <= 4'h0;
    end else if (soft_reset) begin
      bv_r <= 4'h0;
    end else begin
      bv_r[`TWG_BV_PER] <= PERIOD_BUFFER_WRITE || (bv_r[`TWG_BV_PER] && !do_update);
      for (int i = 0; i < 3; i++) begin
        bv_r[i] <= CHANNEL_MATCH_WRITE[i] || (bv_r[i] && !do_update);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          cmp_buf_r[g] <= `TWG_ZERO16;
          cmp_r[g] <= `TWG_ZERO16;
        end else if (soft_reset) begin
          cmp_buf_r[g] <= `TWG_ZERO16;
          cmp_r[g] <= `TWG_ZERO16;
        end else begin
          if (CHANNEL_MATCH_WRITE[g]) begin
            cmp_buf_r[g] <= CHANNEL_MATCH_BUFFER[16*g +: 16];
          end
          if (do_update && bv_r[g]) begin
            cmp_r[g] <= cmp_buf_r[g];
          end
        end
      end

      // match pulse, one clock after a tick with the count on the compare value
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          match_r[g] <= 1'b0;
        end else if (clear_all) begin
          match_r[g] <= 1'b0;
        end else if (DUAL_BYTE_SPLIT) begin
          match_r[g] <= tick && byte_hits(cnt_r[`TWG_LO], cmp_r[g][`TWG_LO]);
        end else begin
          match_r[g] <= tick && hits(cnt_r, cmp_r[g]);
        end
      end

      // waveform per channel: bit g is normal/low byte, bit g+3 the high byte in split mode
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          wo_r[g] <= 1'b0;
          wo_r[g+3] <= 1'b0;
        end else if (clear_all) begin
          wo_r[g] <= 1'b0;
          wo_r[g+3] <= 1'b0;
        end else begin
          if (tick) begin
            if (DUAL_BYTE_SPLIT) begin
              wo_r[g] <= split_level(wo_r[g], cnt_r[`TWG_LO], cmp_r[g][`TWG_LO]);
              wo_r[g+3] <= split_level(wo_r[g+3], cnt_r[`TWG_HI], cmp_r[g][`TWG_HI]);
            end else begin
              // high-byte waveforms fall idle outside split mode
              wo_r[g+3] <= 1'b0;
              case (mode)
                twg_pkg::TWG_FRQ: begin
                  // offset of channels 1, 2 follows from their own compare values on the shared count
                  if (hits(cnt_r, cmp_r[g])) begin
                    wo_r[g] <= !wo_r[g];
                  end
                end
                twg_pkg::TWG_SINGLE: begin
                  if (cmp_r[g] == `TWG_ZERO16) begin
                    wo_r[g] <= 1'b0;
                  end else if (hits(cnt_r, cmp_r[g])) begin
                    wo_r[g] <= 1'b0;
                  end else if (at_bottom) begin
                    wo_r[g] <= 1'b1;
                  end
                end
                twg_pkg::TWG_DUAL: begin
                  if (cmp_r[g] == `TWG_ZERO16) begin
                    wo_r[g] <= 1'b0;
                  end else if (cmp_r[g] >= per_r) begin
                    wo_r[g] <= 1'b1;
                  end else if (hits(cnt_r, cmp_r[g])) begin
                    wo_r[g] <= dir_r;
                  end else if (at_bottom) begin
                    wo_r[g] <= 1'b1;
                  end
                end
                default: begin
                  wo_r[g] <= wo_r[g];
                end
              endcase
            end
          end
        end
      end

      // pin override; direction setup stays with software
      always_comb begin
        PIN_VALUE[g] = PIN_OUTPUT_LATCH[g];
        PIN_VALUE[g+3] = PIN_OUTPUT_LATCH[g+3];
        if (CHANNEL_OUTPUT_ON[g] && wg_on) begin
          PIN_VALUE[g] = wo_r[g] ^ PIN_INVERT[g];
        end
        if (CHANNEL_OUTPUT_ON[g] && DUAL_BYTE_SPLIT) begin
          PIN_VALUE[g+3] = wo_r[g+3] ^ PIN_INVERT[g+3];
        end
      end

      assign CHANNEL_MATCH_VALUE[16*g +: 16] = cmp_r[g];
    end
  endgenerate

  assign WAVE_OUTPUT_N = wo_r;
  assign COUNT_VALUE = cnt_r;
  assign PERIOD_VALUE = per_r;
  assign BUFFER_VALID = bv_r;
  assign MATCH_PULSE = match_r;
endmodule
`default_nettype wire

// *** tb/twg_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module twg_monitor (
  // control
  input wire logic CLK,
  input wire logic RST,
  input wire logic ENABLE,
  input wire logic [2:0] PRESCALE_SELECT,
  input wire logic [2:0] WAVEFORM_KIND,
  input wire logic [2:0] CHANNEL_OUTPUT_ON,
  input wire logic COUNT_DOWN,
  input wire logic UPDATE_LOCK,
  input wire logic DUAL_BYTE_SPLIT,
  input wire logic [1:0] COMMAND,
  input wire logic [2:0] CHANNEL_MATCH_WRITE,
  input wire logic [5:0] PIN_INVERT,
  // observed
  input wire logic [5:0] PIN_VALUE,
  input wire logic [5:0] WAVE_OUTPUT_N,
  input wire logic [15:0] COUNT_VALUE,
  input wire logic [15:0] PERIOD_VALUE,
  input wire logic [47:0] CHANNEL_MATCH_VALUE,
  input wire logic [3:0] BUFFER_VALID,
  input wire logic [2:0] MATCH_PULSE
);
  // full-rate tick with no command: only there are the relations exact
  wire logic tick = ENABLE && PRESCALE_SELECT == 3'h0 && COMMAND == 2'h0 && !DUAL_BYTE_SPLIT;
  wire logic m0 = COUNT_VALUE == CHANNEL_MATCH_VALUE[15:0];
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_restart_clears: assert property (COMMAND == 2'h2 |=> COUNT_VALUE == 16'h0000 && WAVE_OUTPUT_N == 6'h00)
    else $error("restart left state");
  a_freq_toggle: assert property (tick && WAVEFORM_KIND == 3'h1 && COUNT_VALUE == CHANNEL_MATCH_VALUE[31:16]
    |=> WAVE_OUTPUT_N[1] != $past(WAVE_OUTPUT_N[1])) else $error("no toggle on match");
  a_freq_wrap: assert property (tick && WAVEFORM_KIND == 3'h1 && !COUNT_DOWN && m0 |=> COUNT_VALUE == 16'h0000)
    else $error("no wrap at match zero");
  a_single_clear: assert property (tick && WAVEFORM_KIND == 3'h3 && m0 && COUNT_VALUE != PERIOD_VALUE
    |=> !WAVE_OUTPUT_N[0]) else $error("no clear on match");
  a_dual_low: assert property (tick && WAVEFORM_KIND == 3'h5 && m0 && COUNT_VALUE == 16'h0000 && !BUFFER_VALID[0]
    |=> !WAVE_OUTPUT_N[0]) else $error("dual bottom not low");
  a_match_pulse: assert property (tick && m0 |=> MATCH_PULSE[0])
    else $error("no match pulse");
  a_lock_bypass: assert property (COMMAND == 2'h1 && UPDATE_LOCK && !DUAL_BYTE_SPLIT && !CHANNEL_MATCH_WRITE[0]
    |=> !BUFFER_VALID[0]) else $error("update command blocked");
  a_pin_override: assert property (!$past(RST) && $stable(WAVEFORM_KIND) && $stable(PIN_INVERT)
    && CHANNEL_OUTPUT_ON[0] && WAVEFORM_KIND inside {3'h1, 3'h3, 3'h5} && !DUAL_BYTE_SPLIT
    |-> PIN_VALUE[0] == (WAVE_OUTPUT_N[0] ^ PIN_INVERT[0])) else $error("pin not overridden");
  a_idle_hold: assert property (!ENABLE && COMMAND == 2'h0 |=> $stable(COUNT_VALUE))
    else $error("count moved while stopped");
endmodule
bind twg_sixteen_bit_timer twg_monitor u_monitor (.CLK, .RST, .ENABLE, .PRESCALE_SELECT, .WAVEFORM_KIND,
  .CHANNEL_OUTPUT_ON, .COUNT_DOWN, .UPDATE_LOCK, .DUAL_BYTE_SPLIT, .COMMAND, .CHANNEL_MATCH_WRITE,
  .PIN_INVERT, .PIN_VALUE, .WAVE_OUTPUT_N, .COUNT_VALUE, .PERIOD_VALUE, .CHANNEL_MATCH_VALUE,
  .BUFFER_VALID, .MATCH_PULSE);
`default_nettype wire

// *** tb/twg_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module twg_pin_model (
  // port side
  input wire logic [5:0] pin_value,
  input wire logic [5:0] pin_direction,
  output logic [5:0] pad
);
  // a pin left as input floats up through its pull-up
  assign pad = (pin_value & pin_direction) | ~pin_direction;
endmodule
`default_nettype wire

// *** tb/twg_sixteen_bit_timer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module twg_sixteen_bit_timer_bench;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, lock = 1'b0, split = 1'b0, pw = 1'b0;
  logic dn = 1'b0;
  logic [2:0] psc = 3'h0, kind = 3'h0, on = 3'h0, cw = 3'h0;
  logic [1:0] cmd = 2'h0;
  logic [15:0] pb = 16'h0000, cnt, per, lc, p, x;
  logic [47:0] cb = 48'h000000000000, cmv;
  logic [5:0] latch = 6'h00, inv = 6'h00, dir = 6'h3f, pv, wo, lw, pad;
  logic [3:0] bv;
  logic [2:0] mp;
  int n_errors = 0, samples_checked = 0, seed = 40, cyc = 0, hi, nb, tg, w;
  twg_sixteen_bit_timer dut (.CLK(clk), .RST(rst), .ENABLE(en), .PRESCALE_SELECT(psc), .WAVEFORM_KIND(kind),
    .CHANNEL_OUTPUT_ON(on), .COUNT_DOWN(dn), .UPDATE_LOCK(lock), .DUAL_BYTE_SPLIT(split), .COMMAND(cmd),
    .PERIOD_BUFFER(pb), .PERIOD_BUFFER_WRITE(pw), .CHANNEL_MATCH_BUFFER(cb), .CHANNEL_MATCH_WRITE(cw),
    .PIN_OUTPUT_LATCH(latch), .PIN_INVERT(inv), .PIN_VALUE(pv), .WAVE_OUTPUT_N(wo), .COUNT_VALUE(cnt),
    .PERIOD_VALUE(per), .CHANNEL_MATCH_VALUE(cmv), .BUFFER_VALID(bv), .MATCH_PULSE(mp));
  twg_pin_model pins (.pin_value(pv), .pin_direction(dir), .pad(pad));
  always #25 clk = ~clk;
  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // restart while loading the buffers, then force the update: every run starts from a known phase
  task automatic load(input logic [2:0] k, input logic [15:0] pp, c0, input logic [2:0] s);
    @(negedge clk);
    kind = k;
    psc = s;
    pb = pp;
    cb = {c0, c0 >> 1, c0};
    pw = 1'b1;
    cw = 3'h7;
    cmd = 2'h2;
    @(negedge clk);
    pw = 1'b0;
    cw = 3'h0;
    cmd = 2'h1;
    @(negedge clk);
    cmd = 2'h0;
  endtask
  task automatic meas(input int n);
    hi = 0;
    nb = 0;
    tg = 0;
    repeat (n) begin
      lc = cnt;
      lw = wo;
      @(negedge clk);
      hi += wo[0];
      tg += (wo[0] != lw[0]);
      nb += (cnt == 16'h0000 && lc != 16'h0000);
    end
  endtask
  function automatic int exp_high(input int s, input int pp, input int c);
    if (s == 3) return c >= pp ? 2 * pp : 2 * c;
    return (2 << s) * (c > pp ? pp + 1 : c);
  endfunction
  function automatic int div_of(input int s);
    return s < 5 ? 1 << s : 1 << (2 * s - 4);
  endfunction
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    en = 1'b1;
    for (int i = 0; i < 3; i++) begin
      p = i == 0 ? 16'h0000 : 16'({$random(seed)} % 7);
      load(3'h1, 16'hffff, p, 3'h0);
      repeat (4) @(negedge clk);
      meas(4 * (p + 1));
      check("toggles", tg, 4);
    end
    // slow divides: match zero of one toggles every second tick
    for (int s = 3; s < 8; s++) begin
      load(3'h1, 16'hffff, 16'h0001, 3'(s));
      meas(8 * div_of(s));
      check("slow toggles", tg, 4);
    end
    // plan 3 is dual slope at divide one, the rest single slope at divide 1, 2, 4
    for (int s = 0; s < 4; s++) begin
      for (int j = 0; j < 4; j++) begin
        p = 16'h0003 + 16'({$random(seed)} % 5);
        x = j == 3 ? p + 16'h0001 : j == 2 ? p : j == 1 ? 16'({$random(seed)} % p) : 16'h0000;
        load(s == 3 ? 3'h5 : 3'h3, p, x, s == 3 ? 3'h0 : 3'(s));
        w = s == 3 ? 2 * p : (p + 1) * (2 << s);
        repeat (w) @(negedge clk);
        meas(w);
        check("high", hi, exp_high(s, p, x));
        check("bottoms", nb, s == 3 ? 1 : 2);
      end
    end
    on = 3'h1;
    latch = 6'($random(seed));
    inv = 6'($random(seed));
    repeat (2) begin
      @(negedge clk);
      check("pin", {pad[0], pv[0]}, {2{~inv[0]}});
      inv = ~inv;
    end
    kind = 3'h0;
    @(negedge clk);
    check("latch", pv[0], latch[0]);
    cmd = 2'h2;
    @(negedge clk);
    cmd = 2'h0;
    check("restart", {cnt, wo}, 32'h0);
    load(3'h3, 16'h0005, 16'h0002, 3'h0);
    lock = 1'b1;
    cb = {3{16'h0004}};
    cw = 3'h1;
    @(negedge clk);
    cw = 3'h0;
    repeat (12) @(negedge clk);
    check("locked", cmv[15:0], 16'h0002);
    cmd = 2'h1;
    @(negedge clk);
    cmd = 2'h0;
    lock = 1'b0;
    check("forced", cmv[15:0], 16'h0004);
    cb = {3{16'h0001}};
    cw = 3'h1;
    @(negedge clk);
    cw = 3'h0;
    repeat (12) @(negedge clk);
    check("updated", cmv[15:0], 16'h0001);
    cmd = 2'h3;
    @(negedge clk);
    check("refused", per, 16'h0005);
    en = 1'b0;
    @(negedge clk);
    cmd = 2'h0;
    en = 1'b1;
    check("reset", {per, cnt}, 32'hffff0000);
    x = 16'({$random(seed)} % 8);
    load(3'h3, 16'h0405, {8'h02, x[7:0]}, 3'h0);
    split = 1'b1;
    dn = 1'b1;
    repeat (12) @(negedge clk);
    meas(12);
    check("split high", hi, x <= 5 ? 2 * x : 0);
    check("split pin", pv[3], wo[3] ^ inv[3]);
    finish_test();
  end
endmodule
`default_nettype wire
